//--- pgrc_pkg.sv
// Constants shared by both ends of the power gating and reset control link.
// Assumes a single 25 MHz clock on both ends.
package pgrc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // Reset timing figures in their own units
    localparam int POWERUP_MIN_MS = 1;
    localparam int WARM_MIN_NS = 150;
    localparam int RECOVER_MAX_NS = 120;
    localparam int ABORT_MAX_US = 25;
    // Derived cycle counts: least times round up, longest round down
    localparam int POWERUP_CYCLES =
        (POWERUP_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARM_CYCLES = (WARM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYCLES = (RECOVER_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
        RECOVER_MAX_NS / CLK_PERIOD_NS;
    localparam int ABORT_CYCLES = ABORT_MAX_US * 1000 / CLK_PERIOD_NS;
    // Configuration load length after power-up
    localparam int CFG_LOAD_CYCLES = 8;
    // Auto power-down limit in logic clock periods
    localparam logic [3:0] APD_LIMIT = 4'hF;
    // Power management register zero fields
    localparam int REG0_APD_EN_BIT = 1;
    localparam int REG0_STROBE_POL_BIT = 2;
    localparam int REG0_TURBO_OFF_BIT = 3;
    localparam int REG0_CLK_AND_BIT = 4;
    localparam int REG0_CLK_MC_BIT = 5;
    // Power management register two fields
    localparam int REG2_ADDR_BIT = 0;
    localparam int REG2_CTL0_BIT = 2;
    localparam int REG2_CTL1_BIT = 3;
    localparam int REG2_CTL2_BIT = 4;
    localparam int REG2_STROBE_BIT = 5;
    localparam int REG2_BE_BIT = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Register select on the write port
    localparam logic REG_SEL_ZERO = 1'b0;
    localparam logic REG_SEL_TWO = 1'b1;
    // Reset sequencer states
    typedef enum logic [1:0] {
        RS_LOAD = 2'b00,
        RS_HOLD = 2'b01,
        RS_RECOVER = 2'b11,
        RS_RUN = 2'b10
    } pgrc_rst_state_t;
    // Flash state machine modes
    typedef enum logic [1:0] {
        FL_READ = 2'b00,
        FL_PROGRAM = 2'b01,
        FL_ERASE = 2'b11
    } pgrc_flash_mode_t;
endpackage

//--- pgrc_if.sv
// Microcontroller bus pins between the host end and the device end.
// Assumes both ends share clk; the testbench connects the two modports.
`timescale 1ns/100ps
`default_nettype none
interface pgrc_if;
    logic resetN;
    logic chipSelN;
    logic addressStrobe;
    logic logicClockInput;
    logic [7:0] lowAddressByte;
    logic [2:0] busControl;
    logic byteEnable;
    logic regWrite;
    logic regSel;
    logic [7:0] regData;
    // Bus master and reset source
    modport host (
        output resetN, chipSelN, addressStrobe, logicClockInput,
        output lowAddressByte, busControl, byteEnable,
        output regWrite, regSel, regData
    );
    // Documented device
    modport device (
        input resetN, chipSelN, addressStrobe, logicClockInput,
        input lowAddressByte, busControl, byteEnable,
        input regWrite, regSel, regData
    );
endinterface
`default_nettype wire

//--- pgrc_device.sv
// Device end: chip select gating, input blocking, auto power-down and
// reset sequencing with flash state machine abort.
// Assumes bus pins are synchronous to clk and rst_n marks supply power-up.
//
// What this block does
// - Chip select low enables memories and I/O
// - Chip select high disables memories, keeps logic
// - Register zero bits 4/5 cut clock
// - Software should cut unused logic clock
// - Register two bits cut inputs from array
// - Counter counts held strobe, power-down at 15
// - Host holds power-up reset one millisecond
// - Power-up reset loads config, clears registers
// - No memory access during 120 ns recovery
// - Flash comes out of power-up reading
// - Sector selects low during power-up reset
// - Warm reset of 150 ns accepted, recovers
// - Logic outputs valid after config, warm
// - Reset aborts flash program or erase
// - Strobe, chip select or reset wakes
// - Power-down blocks bus from memories, address from logic
`timescale 1ns/100ps
`default_nettype none
module pgrc_device #(
    parameter int CFG_CYCLES = pgrc_pkg::CFG_LOAD_CYCLES,
    parameter int RECOVER = pgrc_pkg::RECOVER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    pgrc_if.device bus,
    input wire logic [7:0] primaryDecode,
    input wire logic [3:0] secondaryDecode,
    input wire logic flashProgramReq,
    input wire logic flashEraseReq,
    input wire logic flashOpDone,
    output logic primaryFlashEn,
    output logic secondaryFlashEn,
    output logic sramEn,
    output logic ioEn,
    output logic logicOutputsValid,
    output logic operational,
    output logic [7:0] primarySectorSelects,
    output logic [3:0] secondarySectorSelects,
    output logic [7:0] memAddress,
    output logic andArrayClock,
    output logic macrocellClock,
    output logic [7:0] arrayAddress,
    output logic [2:0] arrayControl,
    output logic arrayStrobe,
    output logic arrayByteEnable,
    output logic powerDownFlag,
    output logic turboOff,
    output pgrc_pkg::pgrc_flash_mode_t flashMode,
    output logic [7:0] powerMgmtRegZero,
    output logic [7:0] powerMgmtRegTwo
);
    localparam logic [7:0] CFG_LAST = 8'(CFG_CYCLES - 1);
    localparam logic [7:0] REC_LAST = 8'(RECOVER - 1);

    pgrc_pkg::pgrc_rst_state_t rstState, next_rstState;
    logic [7:0] timer, next_timer;
    logic [7:0] next_powerMgmtRegZero, next_powerMgmtRegTwo;
    logic [3:0] apdCount, next_apdCount;
    logic next_powerDownFlag;
    logic strobePrev, next_strobePrev;
    logic clkPrev, next_clkPrev;
    pgrc_pkg::pgrc_flash_mode_t next_flashMode;
    logic strobeEdge, clkRise, running, selected;

    // Edge detection on the sampled strobe and logic clock pins
    assign strobeEdge = bus.addressStrobe != strobePrev;
    assign clkRise = bus.logicClockInput && !clkPrev;
    assign running = rstState == pgrc_pkg::RS_RUN;

    // Reset sequencer: config load, reset hold and recovery
    always_comb begin
        next_rstState = rstState;
        next_timer = timer;
        unique case (rstState)
            pgrc_pkg::RS_LOAD: begin
                next_timer = timer + 8'h01;
                if (timer == CFG_LAST) begin
                    next_rstState = pgrc_pkg::RS_HOLD;
                    next_timer = 8'h00;
                end
            end
            pgrc_pkg::RS_HOLD: begin
                if (bus.resetN) begin
                    // The sampling cycle already counts toward recovery
                    next_rstState = pgrc_pkg::RS_RECOVER;
                    next_timer = 8'h01;
                end
            end
            pgrc_pkg::RS_RECOVER: begin
                next_timer = timer + 8'h01;
                if (timer >= REC_LAST) begin
                    next_rstState = pgrc_pkg::RS_RUN;
                end
            end
            pgrc_pkg::RS_RUN: begin
                next_timer = 8'h00;
            end
        endcase
        // A low sample of the reset pin outside config load restarts the hold
        if (!bus.resetN && rstState != pgrc_pkg::RS_LOAD) begin
            next_rstState = pgrc_pkg::RS_HOLD;
            next_timer = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstState <= pgrc_pkg::RS_LOAD;
            timer <= 8'h00;
        end else begin
            rstState <= next_rstState;
            timer <= next_timer;
        end
    end

    // Power management registers, cleared while in reset
    always_comb begin
        next_powerMgmtRegZero = powerMgmtRegZero;
        next_powerMgmtRegTwo = powerMgmtRegTwo;
        if (!running) begin
            next_powerMgmtRegZero = pgrc_pkg::REG_RESET;
            next_powerMgmtRegTwo = pgrc_pkg::REG_RESET;
        end else if (bus.regWrite) begin
            if (bus.regSel == pgrc_pkg::REG_SEL_ZERO) begin
                next_powerMgmtRegZero = bus.regData;
            end else begin
                next_powerMgmtRegTwo = bus.regData;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerMgmtRegZero <= pgrc_pkg::REG_RESET;
            powerMgmtRegTwo <= pgrc_pkg::REG_RESET;
        end else begin
            powerMgmtRegZero <= next_powerMgmtRegZero;
            powerMgmtRegTwo <= next_powerMgmtRegTwo;
        end
    end

    // Auto power-down counter and flag
    always_comb begin
        next_strobePrev = bus.addressStrobe;
        next_clkPrev = bus.logicClockInput;
        next_apdCount = apdCount;
        next_powerDownFlag = powerDownFlag;
        if (!running || !bus.chipSelN ||
                !powerMgmtRegZero[pgrc_pkg::REG0_APD_EN_BIT]) begin
            next_apdCount = 4'h0;
            next_powerDownFlag = 1'b0;
        end else if (strobeEdge) begin
            next_apdCount = 4'h0;
            next_powerDownFlag = 1'b0;
        end else if (bus.addressStrobe ==
                powerMgmtRegZero[pgrc_pkg::REG0_STROBE_POL_BIT] && clkRise &&
                apdCount != pgrc_pkg::APD_LIMIT) begin
            next_apdCount = apdCount + 4'h1;
            if (apdCount == pgrc_pkg::APD_LIMIT - 4'h1) begin
                next_powerDownFlag = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobePrev <= 1'b0;
            clkPrev <= 1'b0;
            apdCount <= 4'h0;
            powerDownFlag <= 1'b0;
        end else begin
            strobePrev <= next_strobePrev;
            clkPrev <= next_clkPrev;
            apdCount <= next_apdCount;
            powerDownFlag <= next_powerDownFlag;
        end
    end

    // Flash state machine: reset returns it to read at once
    always_comb begin
        next_flashMode = flashMode;
        unique case (flashMode)
            pgrc_pkg::FL_READ: begin
                if (running && selected && flashEraseReq) begin
                    next_flashMode = pgrc_pkg::FL_ERASE;
                end else if (running && selected && flashProgramReq) begin
                    next_flashMode = pgrc_pkg::FL_PROGRAM;
                end
            end
            pgrc_pkg::FL_PROGRAM, pgrc_pkg::FL_ERASE: begin
                if (flashOpDone) begin
                    next_flashMode = pgrc_pkg::FL_READ;
                end
            end
            default: begin
                next_flashMode = pgrc_pkg::FL_READ;
            end
        endcase
        if (!running || !bus.resetN) begin
            next_flashMode = pgrc_pkg::FL_READ;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flashMode <= pgrc_pkg::FL_READ;
        end else begin
            flashMode <= next_flashMode;
        end
    end

    // Memory enables from chip select, reset and power-down; I/O enable from chip select and reset
    assign selected = !bus.chipSelN && running && !powerDownFlag;
    assign primaryFlashEn = selected;
    assign secondaryFlashEn = selected;
    assign sramEn = selected;
    assign ioEn = !bus.chipSelN && running;
    assign operational = running;
    assign logicOutputsValid = rstState != pgrc_pkg::RS_LOAD;
    assign turboOff = powerMgmtRegZero[pgrc_pkg::REG0_TURBO_OFF_BIT];

    // Sector selects held low until out of reset
    assign primarySectorSelects =
        selected ? primaryDecode : 8'h00;
    assign secondarySectorSelects = selected ? secondaryDecode : 4'h0;
    assign memAddress = selected ? bus.lowAddressByte : 8'h00;

    // Clock and input blocking toward the logic array
    assign andArrayClock = bus.logicClockInput &&
        !powerMgmtRegZero[pgrc_pkg::REG0_CLK_AND_BIT];
    assign macrocellClock = bus.logicClockInput &&
        !powerMgmtRegZero[pgrc_pkg::REG0_CLK_MC_BIT];
    assign arrayAddress = (powerDownFlag ||
        powerMgmtRegTwo[pgrc_pkg::REG2_ADDR_BIT]) ? 8'h00 :
        bus.lowAddressByte;
    assign arrayControl[0] = bus.busControl[0] &&
        !powerMgmtRegTwo[pgrc_pkg::REG2_CTL0_BIT];
    assign arrayControl[1] = bus.busControl[1] &&
        !powerMgmtRegTwo[pgrc_pkg::REG2_CTL1_BIT];
    assign arrayControl[2] = bus.busControl[2] &&
        !powerMgmtRegTwo[pgrc_pkg::REG2_CTL2_BIT];
    assign arrayStrobe = bus.addressStrobe &&
        !powerMgmtRegTwo[pgrc_pkg::REG2_STROBE_BIT];
    assign arrayByteEnable = bus.byteEnable &&
        !powerMgmtRegTwo[pgrc_pkg::REG2_BE_BIT];
endmodule
`default_nettype wire

//--- pgrc_host.sv
// Host end: reset source and bus master for the power control device.
// Assumes user-side requests are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pgrc_host #(
    parameter int POWERUP = pgrc_pkg::POWERUP_CYCLES,
    parameter int WARM = pgrc_pkg::WARM_CYCLES,
    parameter int RECOVER = pgrc_pkg::RECOVER_CYCLES,
    parameter int CLK_DIV = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    pgrc_if.host bus,
    input wire logic warmResetReq,
    input wire logic chipSelect,
    input wire logic strobeLevel,
    input wire logic [7:0] address,
    input wire logic [2:0] control,
    input wire logic byteEn,
    input wire logic writeReq,
    input wire logic writeSel,
    input wire logic [7:0] writeData,
    output logic ready
);
    logic [15:0] rstTimer, next_rstTimer;
    logic [7:0] recTimer, next_recTimer;
    logic [7:0] divCount, next_divCount;
    logic resetLow, next_resetLow;
    logic next_ready;
    logic divClk, next_divClk;

    // Reset pulse generation and recovery wait before access
    always_comb begin
        next_rstTimer = rstTimer;
        next_resetLow = resetLow;
        next_recTimer = recTimer;
        next_ready = ready;
        if (resetLow) begin
            next_rstTimer = rstTimer - 16'h0001;
            if (rstTimer == 16'h0001) begin
                next_resetLow = 1'b0;
                next_recTimer = 8'(RECOVER);
            end
        end else if (warmResetReq) begin
            next_resetLow = 1'b1;
            next_rstTimer = 16'(WARM);
            next_ready = 1'b0;
        end else if (recTimer != 8'h00) begin
            next_recTimer = recTimer - 8'h01;
            next_ready = recTimer == 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstTimer <= 16'(POWERUP);
            resetLow <= 1'b1;
            recTimer <= 8'h00;
            ready <= 1'b0;
        end else begin
            rstTimer <= next_rstTimer;
            resetLow <= next_resetLow;
            recTimer <= next_recTimer;
            ready <= next_ready;
        end
    end

    // Logic clock divider: the level toggles every CLK_DIV cycles
    always_comb begin
        next_divCount = divCount + 8'h01;
        next_divClk = divClk;
        if (divCount == 8'(CLK_DIV - 1)) begin
            next_divCount = 8'h00;
            next_divClk = !divClk;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= 8'h00;
            divClk <= 1'b0;
        end else begin
            divCount <= next_divCount;
            divClk <= next_divClk;
        end
    end

    // Bus drive; register write held low until ready
    assign bus.resetN = !resetLow;
    assign bus.logicClockInput = divClk;
    assign bus.chipSelN = !(chipSelect && ready);
    assign bus.addressStrobe = strobeLevel;
    assign bus.lowAddressByte = address;
    assign bus.busControl = ready ? control : 3'h1;
    assign bus.byteEnable = byteEn;
    assign bus.regWrite = writeReq && ready;
    assign bus.regSel = writeSel;
    assign bus.regData = writeData;
endmodule
`default_nettype wire

//--- pgrc_properties.sv
// Concurrent checks on the bus pins and the device end outputs.
// Assumes one clock; the bench instantiates it beside the interface.
`timescale 1ns/100ps
`default_nettype none
module pgrc_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic resetN,
    input wire logic chipSelN,
    input wire logic addressStrobe,
    input wire logic primaryFlashEn,
    input wire logic secondaryFlashEn,
    input wire logic sramEn,
    input wire logic logicOutputsValid,
    input wire logic operational,
    input wire logic [7:0] arrayAddress,
    input wire logic [2:0] arrayControl,
    input wire logic arrayStrobe,
    input wire logic arrayByteEnable,
    input wire logic powerDownFlag,
    input wire pgrc_pkg::pgrc_flash_mode_t flashMode,
    input wire logic [7:0] powerMgmtRegZero,
    input wire logic [7:0] powerMgmtRegTwo
);
    // Cycles the strobe has sat still at the counting level
    logic [6:0] quietCnt;
    logic [6:0] next_quietCnt;
    logic lastStrobe;
    always_comb begin
        next_quietCnt = 7'h00;
        if (powerMgmtRegZero[1] && chipSelN && operational &&
            addressStrobe == powerMgmtRegZero[2] &&
            addressStrobe == lastStrobe) begin
            next_quietCnt = quietCnt + 7'(quietCnt != 7'h7F);
        end
    end
    // Counter and last strobe level registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quietCnt <= 7'h00;
            lastStrobe <= 1'b0;
        end else begin
            quietCnt <= next_quietCnt;
            lastStrobe <= addressStrobe;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_cs_low_memon:
        assert property (!chipSelN && operational && !powerDownFlag |->
            primaryFlashEn && secondaryFlashEn && sramEn)
            else $error("mem off");
    a_cs_high_memoff:
        assert property (chipSelN |-> !primaryFlashEn && !secondaryFlashEn &&
            !sramEn) else $error("memory enabled while deselected");
    a_inputs_blocked:
        assert property (((arrayControl & powerMgmtRegTwo[4:2]) == 3'h0) &&
            !(arrayStrobe && powerMgmtRegTwo[5]) &&
            !(arrayByteEnable && powerMgmtRegTwo[6]) &&
            !(powerMgmtRegTwo[0] && arrayAddress != 8'h00))
            else $error("blocked input reached the array");
    a_pd_not_early:
        assert property ($rose(powerDownFlag) |-> quietCnt >= 7'h34)
            else $error("power-down before fifteen clocks");
    a_pd_by_limit:
        assert property (quietCnt >= 7'h50 |-> powerDownFlag)
            else $error("power-down missing after quiet strobe");
    a_regs_cleared:
        assert property (!operational && !$past(operational) |->
            powerMgmtRegZero == 8'h00 && powerMgmtRegTwo == 8'h00)
            else $error("power registers not cleared in reset");
    a_recover_wait:
        assert property ($rose(resetN) |->
            !operational[*3] ##1 operational)
            else $error("recovery interval wrong");
    a_outputs_stay:
        assert property (logicOutputsValid |=> logicOutputsValid)
            else $error("logic outputs dropped");
    a_reset_aborts:
        assert property (!resetN && operational |=> !operational &&
            flashMode == pgrc_pkg::FL_READ) else $error("flash not aborted");
    a_pd_wakes:
        assert property (powerDownFlag && ($changed(addressStrobe) ||
            !chipSelN || !resetN) |-> ##[1:2] !powerDownFlag)
            else $error("power-down did not end");
    a_pd_blocks_bus:
        assert property (powerDownFlag |-> arrayAddress == 8'h00 &&
            !primaryFlashEn && !sramEn) else $error("bus not blocked");
endmodule
`default_nettype wire

//--- pgrc_tb.sv
// Bench joining the host end and the device end over the shared bus.
// Assumes a 25 MHz clock; the host power-up hold is cut to 20 cycles.
`timescale 1ns/100ps
`default_nettype none
module pgrc_tb;
    logic clk, rst_n, warmResetReq, chipSelect, strobeLevel, byteEn;
    logic writeReq, writeSel, ready, flashProgramReq, flashEraseReq;
    logic flashOpDone, primaryFlashEn, secondaryFlashEn, sramEn, ioEn;
    logic logicOutputsValid, operational, andArrayClock, macrocellClock;
    logic arrayStrobe, arrayByteEnable, powerDownFlag, turboOff;
    logic [7:0] memAddress, seenBits;
    logic [7:0] address, writeData, primaryDecode, primarySectorSelects;
    logic [7:0] arrayAddress, powerMgmtRegZero, powerMgmtRegTwo, expBits;
    logic [3:0] secondaryDecode, secondarySectorSelects;
    logic [2:0] control, arrayControl;
    pgrc_pkg::pgrc_flash_mode_t flashMode;
    int errorCnt, checksDone, i;
    // 40 ns clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    pgrc_if pgrc_if_i ();
    pgrc_host #(.POWERUP(20)) pgrc_host_i (.clk(clk), .rst_n(rst_n),
        .bus(pgrc_if_i.host), .warmResetReq(warmResetReq),
        .chipSelect(chipSelect), .strobeLevel(strobeLevel),
        .address(address), .control(control), .byteEn(byteEn),
        .writeReq(writeReq), .writeSel(writeSel), .writeData(writeData),
        .ready(ready));
    pgrc_device pgrc_device_i (.clk(clk), .rst_n(rst_n),
        .bus(pgrc_if_i.device), .primaryDecode(primaryDecode),
        .secondaryDecode(secondaryDecode), .flashProgramReq(flashProgramReq),
        .flashEraseReq(flashEraseReq), .flashOpDone(flashOpDone),
        .primaryFlashEn(primaryFlashEn), .sramEn(sramEn), .ioEn(ioEn),
        .secondaryFlashEn(secondaryFlashEn), .operational(operational),
        .logicOutputsValid(logicOutputsValid), .memAddress(memAddress),
        .primarySectorSelects(primarySectorSelects), .turboOff(turboOff),
        .secondarySectorSelects(secondarySectorSelects),
        .andArrayClock(andArrayClock), .macrocellClock(macrocellClock),
        .arrayAddress(arrayAddress), .arrayControl(arrayControl),
        .arrayStrobe(arrayStrobe), .arrayByteEnable(arrayByteEnable),
        .powerDownFlag(powerDownFlag), .flashMode(flashMode),
        .powerMgmtRegZero(powerMgmtRegZero),
        .powerMgmtRegTwo(powerMgmtRegTwo));
    pgrc_properties pgrc_properties_i (.clk(clk), .rst_n(rst_n),
        .resetN(pgrc_if_i.resetN), .chipSelN(pgrc_if_i.chipSelN),
        .addressStrobe(pgrc_if_i.addressStrobe), .sramEn(sramEn),
        .primaryFlashEn(primaryFlashEn), .secondaryFlashEn(secondaryFlashEn),
        .logicOutputsValid(logicOutputsValid), .operational(operational),
        .arrayAddress(arrayAddress), .arrayControl(arrayControl),
        .arrayStrobe(arrayStrobe), .arrayByteEnable(arrayByteEnable),
        .powerDownFlag(powerDownFlag), .flashMode(flashMode),
        .powerMgmtRegZero(powerMgmtRegZero),
        .powerMgmtRegTwo(powerMgmtRegTwo));
    // Verdict and end of run
    task automatic endSim();
        $display("Checks: %0d, mismatches: %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Move to just after a later rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // One register write through the host, then wait for it to land
    task automatic writeReg(input logic sel, input logic [7:0] data);
        int n;
        {writeSel, writeData, writeReq} = {sel, data, 1'b1};
        step(1);
        writeReq = 1'b0;
        for (n = 0; n < 8; n++) begin
            if ((sel ? powerMgmtRegTwo : powerMgmtRegZero) === data) break;
            step(1);
        end
        check(sel ? powerMgmtRegTwo : powerMgmtRegZero, data);
        if (n == 8) endSim();
    endtask
    // Bounded waits on the ready and power-down outputs
    task automatic waitReady();
        int n;
        for (n = 0; n < 60 && ready !== 1'b1; n++) step(1);
        check(8'(ready), 8'h01);
        if (n == 60) endSim();
    endtask
    task automatic waitPd(input logic want, input int limit);
        int n;
        for (n = 0; n < limit && powerDownFlag !== want; n++) step(1);
        check(8'(powerDownFlag), 8'(want));
        if (n == limit) endSim();
    endtask
    // Warm reset request; logic outputs stay valid meanwhile
    task automatic pulseReset();
        warmResetReq = 1'b1;
        step(1);
        warmResetReq = 1'b0;
        step(2);
        check(8'(ready), 8'h00);
        check(8'(logicOutputsValid), 8'h01);
    endtask
    // Main sequence
    initial begin
        {rst_n, warmResetReq, chipSelect, writeReq, writeSel} = 5'h00;
        {flashProgramReq, flashEraseReq, flashOpDone} = 3'h0;
        {strobeLevel, byteEn, control, address} = 13'h1FFF;
        {writeData, primaryDecode, secondaryDecode} = 20'h00A56;
        {errorCnt, checksDone} = 64'h0;
        repeat (6) @(posedge clk);
        #2;
        rst_n = 1'b1;
        step(2);
        check(powerMgmtRegZero | powerMgmtRegTwo, 8'h00);
        check(8'(turboOff), 8'h00);
        check(8'(logicOutputsValid), 8'h00);
        check(8'(flashMode), 8'(pgrc_pkg::FL_READ));
        check(8'(pgrc_if_i.busControl), 8'h01);
        check(primarySectorSelects, 8'h00);
        check(8'(operational), 8'h00);
        waitReady();
        check(8'(operational), 8'h01);
        check(8'(logicOutputsValid), 8'h01);
        // Chip select gates memories and I/O, not the array address
        expBits = {5'h00, primaryFlashEn, secondaryFlashEn, sramEn};
        check(expBits, 8'h00);
        check(memAddress, 8'h00);
        check(arrayAddress, 8'hFF);
        chipSelect = 1'b1;
        step(2);
        expBits = {5'h00, primaryFlashEn, secondaryFlashEn, sramEn};
        check(expBits, 8'h07);
        check(memAddress, 8'hFF);
        check(primarySectorSelects, 8'hA5);
        check({3'h0, ioEn, secondarySectorSelects}, 8'h16);
        chipSelect = 1'b0;
        // Logic clock cut from the array, then from the macrocells
        for (i = 0; i < 2; i++) begin
            writeReg(1'b0, 8'h10 << i);
            repeat (6) begin
                expBits = 8'({pgrc_if_i.logicClockInput & i[0],
                    pgrc_if_i.logicClockInput & ~i[0]});
                seenBits = 8'({andArrayClock, macrocellClock});
                check(seenBits, expBits);
                step(1);
            end
        end
        // Each input blocking bit of register two in turn
        for (i = 0; i < 7; i++) begin
            if (i != 1) begin
                writeReg(1'b1, 8'h01 << i);
                check(arrayAddress, (i == 0) ? 8'h00 : 8'hFF);
                expBits = (i == 0) ? 8'h1F :
                    8'h1F & ~(8'h01 << ((i < 5) ? i : 6 - i));
                seenBits = 8'({arrayControl, arrayStrobe, arrayByteEnable});
                check(seenBits, expBits);
            end
        end
        writeReg(1'b1, 8'h00);
        // Strobe held at the other level never counts
        writeReg(1'b0, 8'h02);
        step(90);
        check(8'(powerDownFlag), 8'h00);
        // Counting level, with turbo off and both logic clock paths cut
        writeReg(1'b0, 8'h3E);
        step(48);
        check(8'(powerDownFlag), 8'h00);
        waitPd(1'b1, 40);
        check(arrayAddress | 8'(primaryFlashEn), 8'h00);
        check(8'({andArrayClock, macrocellClock}), 8'h00);
        // Strobe pulse wakes and restarts the count from zero
        strobeLevel = 1'b0;
        step(1);
        strobeLevel = 1'b1;
        waitPd(1'b0, 3);
        step(45);
        check(8'(powerDownFlag), 8'h00);
        waitPd(1'b1, 40);
        chipSelect = 1'b1;
        waitPd(1'b0, 4);
        chipSelect = 1'b0;
        waitPd(1'b1, 80);
        pulseReset();
        waitPd(1'b0, 4);
        waitReady();
        check(powerMgmtRegZero, 8'h00);
        check(8'(turboOff), 8'h00);
        // Program cycle aborted by warm reset
        {chipSelect, flashProgramReq} = 2'h3;
        step(3);
        check(8'(flashMode), 8'(pgrc_pkg::FL_PROGRAM));
        flashProgramReq = 1'b0;
        pulseReset();
        check(8'(flashMode), 8'(pgrc_pkg::FL_READ));
        waitReady();
        // Erase wins over program and ends on done
        {flashProgramReq, flashEraseReq} = 2'h3;
        step(3);
        check(8'(flashMode), 8'(pgrc_pkg::FL_ERASE));
        {flashProgramReq, flashEraseReq, flashOpDone} = 3'h1;
        step(2);
        check(8'(flashMode), 8'(pgrc_pkg::FL_READ));
        endSim();
    end
endmodule
`default_nettype wire
